// file: acs_pkg.sv
// shared constants and types for the serial clock sequencer of the converter
// assumes a 100 MHz system clock and a host-driven serial clock on its own pin
package acs_pkg;

    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int CMD_BITS = 4;
    localparam int RES_BITS = 10;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
    localparam logic [CNT_W-1:0] CMD_EDGES = 5'h04;
    localparam logic [CNT_W-1:0] SAMPLE_OPEN_EDGE = 5'h04;
    localparam logic [CNT_W-1:0] HANDOFF_EDGE = 5'h0A;
    localparam logic [CNT_W-1:0] OUT_EDGES = 5'h0A;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [CMD_BITS-1:0] CMD_RESET = 4'h0;
    localparam logic [RES_BITS-1:0] RESULT_RESET = 10'h000;
    localparam logic MODE_RESET = 1'b1;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 5000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 3;

    // ************************************************************
    // conversion control states
    // ************************************************************
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b001,
        ACS_EXT = 3'b010,
        ACS_CONV = 3'b100
    } acs_state_t;

endpackage

// file: acs_sync.sv
// three-stage synchroniser with agreement filter for a bundle of levels
// assumes each bit is a level that changes rarely against the clock
`timescale 1ns/1ps
module acs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // levels from another domain
    input wire logic [WIDTH-1:0] async_in,
    // filtered level
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    // ************************************************************
    // stages
    // ************************************************************
    // first stage feeds only the second, to keep metastability contained
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            stage1_reg <= INIT;
            stage2_reg <= INIT;
            stage3_reg <= INIT;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a bit changes only once the second and third stages agree
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            level_out <= INIT;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_out[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule

// file: acs_sequencer.sv
// edge-counting sequencer for a serial successive-approximation converter
// assumes the host makes the serial clock and chip select; the analog core
// supplies its result word at the end of the conversion time
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int CONV_COUNT = acs_pkg::CONV_CYCLES
) (
    // system clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // host serial link
    input wire logic io_clk_in,
    input wire logic cs_bar_in,
    input wire logic frame_marker_in,
    input wire logic serial_data_in,
    input wire logic clock_polarity_select_in,
    input wire logic sample_start_bar_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    // analog core
    input wire logic [acs_pkg::RES_BITS-1:0] sar_result_in,
    output logic [acs_pkg::CMD_BITS-1:0] mux_address_out,
    output logic sampling_out,
    output logic conv_start_out,
    output logic conversion_done_out
);

    // ************************************************************
    // helpers
    // ************************************************************
    // command bits are taken on the rising edge when mode and polarity match
    function automatic logic capture_on_rise(input logic mp_mode, input logic pol);
        capture_on_rise = (mp_mode == pol);
    endfunction

    // output bit for a given edge count, zero once the result is spent
    function automatic logic result_bit(input logic [RES_BITS-1:0] res, input logic [CNT_W-1:0] idx);
        logic [CNT_W-1:0] pos;
        pos = OUT_EDGES - 5'h01 - idx;
        if (idx < OUT_EDGES) begin
            result_bit = res[pos[3:0]];
        end else begin
            result_bit = 1'b0;
        end
    endfunction

    // ************************************************************
    // link domain state
    // ************************************************************
    logic mode_reg;
    logic [CNT_W-1:0] rise_cnt_reg;
    logic [CNT_W-1:0] fall_cnt_reg;
    logic [CMD_BITS-1:0] cmd_rise_reg;
    logic [CMD_BITS-1:0] cmd_fall_reg;
    logic open_rise_reg;
    logic open_fall_reg;
    logic close_rise_reg;
    logic close_fall_reg;
    logic take_rise;
    logic take_fall;
    logic count_rise;
    logic count_fall;

    // ************************************************************
    // system domain state
    // ************************************************************
    acs_state_t state_reg;
    logic [RES_BITS-1:0] result_reg;
    logic [15:0] conv_cnt_reg;
    logic close_prev_reg;
    logic start_prev_reg;
    logic [13:0] link_levels;
    logic [13:0] link_sync;
    logic start_sync;
    logic s_mode;
    logic s_pol;
    logic s_open_rise;
    logic s_open_fall;
    logic s_close_rise;
    logic s_close_fall;
    logic [CMD_BITS-1:0] s_cmd_rise;
    logic [CMD_BITS-1:0] s_cmd_fall;
    logic s_close;
    logic s_window;
    logic handoff;
    logic ext_fall;
    logic ext_rise;

    // ************************************************************
    // mode flag
    // ************************************************************
    // caught on each chip select fall; system reset gives a known mode first
    always_ff @(negedge cs_bar_in or posedge reset_in) begin
        if (reset_in) begin
            mode_reg <= MODE_RESET;
        end else begin
            mode_reg <= frame_marker_in;
        end
    end

    // ************************************************************
    // edge qualifiers
    // ************************************************************
    // DSP frames count only while the frame marker is low
    assign count_rise = mode_reg || !frame_marker_in;
    assign count_fall = mode_reg || !frame_marker_in;
    // the capture gate closes after four bits
    assign take_rise = capture_on_rise(mode_reg, clock_polarity_select_in) && (rise_cnt_reg < CMD_EDGES);
    assign take_fall = !capture_on_rise(mode_reg, clock_polarity_select_in) && (fall_cnt_reg < CMD_EDGES);

    // ************************************************************
    // rising-edge logic of the serial clock
    // ************************************************************
    // chip select high holds everything at rest, so each frame starts clean
    always_ff @(posedge io_clk_in or posedge cs_bar_in) begin
        if (cs_bar_in) begin
            rise_cnt_reg <= '0;
            cmd_rise_reg <= CMD_RESET;
        end else if (!count_rise) begin
            rise_cnt_reg <= '0;
        end else begin
            if (rise_cnt_reg != CNT_MAX) begin
                rise_cnt_reg <= rise_cnt_reg + 5'h01;
            end
            if (take_rise) begin
                cmd_rise_reg <= {cmd_rise_reg[CMD_BITS-2:0], serial_data_in};
            end
        end
    end

    // window marks taken on rising edges
    always_ff @(posedge io_clk_in or posedge cs_bar_in) begin
        if (cs_bar_in) begin
            open_rise_reg <= 1'b0;
            close_rise_reg <= 1'b0;
        end else if (count_rise) begin
            if (!mode_reg && rise_cnt_reg == SAMPLE_OPEN_EDGE - 5'h01) begin
                open_rise_reg <= 1'b1;
            end
            if (mode_reg && rise_cnt_reg == HANDOFF_EDGE - 5'h01) begin
                close_rise_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // falling-edge logic of the serial clock
    // ************************************************************
    // in DSP mode a high frame marker on a falling edge restarts the count
    always_ff @(negedge io_clk_in or posedge cs_bar_in) begin
        if (cs_bar_in) begin
            fall_cnt_reg <= '0;
            cmd_fall_reg <= CMD_RESET;
        end else if (!count_fall) begin
            fall_cnt_reg <= '0;
        end else begin
            if (fall_cnt_reg != CNT_MAX) begin
                fall_cnt_reg <= fall_cnt_reg + 5'h01;
            end
            if (take_fall) begin
                cmd_fall_reg <= {cmd_fall_reg[CMD_BITS-2:0], serial_data_in};
            end
        end
    end

    // window marks taken on falling edges
    always_ff @(negedge io_clk_in or posedge cs_bar_in) begin
        if (cs_bar_in) begin
            open_fall_reg <= 1'b0;
            close_fall_reg <= 1'b0;
        end else if (count_fall) begin
            if (mode_reg && fall_cnt_reg == SAMPLE_OPEN_EDGE - 5'h01) begin
                open_fall_reg <= 1'b1;
            end
            if (!mode_reg && fall_cnt_reg == HANDOFF_EDGE - 5'h01) begin
                close_fall_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // serial output
    // ************************************************************
    // the edge counts double as the bit index; the result word is held still
    // while a frame runs, because a new one lands only after the handoff
    assign serial_data_out = mode_reg ? result_bit(result_reg, fall_cnt_reg)
                                      : result_bit(result_reg, rise_cnt_reg);
    // driven whenever chip select is low
    assign serial_data_oe_out = !cs_bar_in;

    // ************************************************************
    // crossing into the system domain
    // ************************************************************
    // the polarity strap rides along so the system side never reads the pin raw
    assign link_levels = {clock_polarity_select_in, cmd_fall_reg, cmd_rise_reg, close_fall_reg, close_rise_reg,
                          open_fall_reg, open_rise_reg, mode_reg};

    acs_sync #(
        .WIDTH(14),
        .INIT(14'h0001)
    ) u_link_sync (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .async_in(link_levels),
        .level_out(link_sync)
    );

    // the sample-start pin idles high
    acs_sync #(
        .WIDTH(1),
        .INIT(1'b1)
    ) u_start_sync (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .async_in(sample_start_bar_in),
        .level_out(start_sync)
    );

    assign s_mode = link_sync[0];
    assign s_open_rise = link_sync[1];
    assign s_open_fall = link_sync[2];
    assign s_close_rise = link_sync[3];
    assign s_close_fall = link_sync[4];
    assign s_cmd_rise = link_sync[8:5];
    assign s_cmd_fall = link_sync[12:9];
    assign s_pol = link_sync[13];

    // ************************************************************
    // event detection
    // ************************************************************
    // the close mark on the tenth edge (rising in microprocessor mode, falling in DSP mode) is the handoff
    assign s_close = s_mode ? s_close_rise : s_close_fall;
    assign s_window = s_mode ? (s_open_fall && !s_close_rise) : (s_open_rise && !s_close_fall);
    assign handoff = s_close && !close_prev_reg;
    assign ext_fall = !start_sync && start_prev_reg;
    assign ext_rise = start_sync && !start_prev_reg;

    // previous values for edge detection
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            close_prev_reg <= 1'b0;
            start_prev_reg <= 1'b1;
        end else begin
            close_prev_reg <= s_close;
            start_prev_reg <= start_sync;
        end
    end

    // ************************************************************
    // conversion control
    // ************************************************************
    // an extended cycle overrides the clock window and the clock handoff
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_reg <= ACS_IDLE;
        end else begin
            case (state_reg)
                ACS_IDLE: begin
                    if (ext_fall) begin
                        state_reg <= ACS_EXT;
                    end else if (handoff) begin
                        state_reg <= ACS_CONV;
                    end
                end
                ACS_EXT: begin
                    if (ext_rise) begin
                        state_reg <= ACS_CONV;
                    end
                end
                ACS_CONV: begin
                    if (conv_cnt_reg == 16'h0000) begin
                        state_reg <= ACS_IDLE;
                    end
                end
                default: begin
                    state_reg <= ACS_IDLE;
                end
            endcase
        end
    end

    // conversion timer, loaded on entry to the conversion
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            conv_cnt_reg <= 16'h0000;
        end else if (state_reg != ACS_CONV) begin
            conv_cnt_reg <= 16'(CONV_COUNT - 1);
        end else if (conv_cnt_reg != 16'h0000) begin
            conv_cnt_reg <= conv_cnt_reg - 16'h0001;
        end
    end

    // done drops at the handoff and rises when the result is stored
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            conversion_done_out <= 1'b1;
            result_reg <= RESULT_RESET;
        end else if (state_reg == ACS_CONV && conv_cnt_reg == 16'h0000) begin
            conversion_done_out <= 1'b1;
            result_reg <= sar_result_in;
        end else if ((state_reg == ACS_IDLE && handoff && !ext_fall) || (state_reg == ACS_EXT && ext_rise)) begin
            conversion_done_out <= 1'b0;
        end
    end

    // start strobe for the analog core, one cycle at the handoff
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            conv_start_out <= 1'b0;
        end else begin
            conv_start_out <= (state_reg == ACS_IDLE && handoff && !ext_fall) || (state_reg == ACS_EXT && ext_rise);
        end
    end

    // sampling switch: clock window, or the whole extended low time
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sampling_out <= 1'b0;
        end else if (state_reg == ACS_EXT) begin
            sampling_out <= !ext_rise;
        end else if (state_reg == ACS_IDLE) begin
            sampling_out <= s_window && !ext_fall;
        end else begin
            sampling_out <= 1'b0;
        end
    end

    // channel address, reloaded every idle cycle once the open mark of the fourth edge is set
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            mux_address_out <= CMD_RESET;
        end else if (state_reg == ACS_IDLE && (s_mode ? s_open_fall : s_open_rise)) begin
            if (capture_on_rise(s_mode, s_pol)) begin
                mux_address_out <= s_cmd_rise;
            end else begin
                mux_address_out <= s_cmd_fall;
            end
        end
    end

endmodule

// file: acs_sequencer_checker.sv
// concurrent checks on the sequencer's ports
// assumes binding onto acs_sequencer, ref clock domain only
`timescale 1ns/1ps
module acs_sequencer_checker
    import acs_pkg::*;
#(
    parameter int CONV_COUNT = acs_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // link side
    input wire logic io_clk_in,
    input wire logic cs_bar_in,
    input wire logic frame_marker_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_out,
    // core side
    input wire logic [acs_pkg::CMD_BITS-1:0] mux_address_out,
    input wire logic sampling_out,
    input wire logic conv_start_out,
    input wire logic conversion_done_out
);
    // ****
    // checks
    // ****
    localparam int LO = CONV_COUNT - 1;
    localparam int HI = CONV_COUNT + 1;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    chk_oe_follows_cs: assert property (serial_data_oe_out == !cs_bar_in)
        else $error("output enable differs from select");
    chk_start_one_cycle: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse too long");
    chk_done_with_start: assert property ($fell(conversion_done_out) |-> conv_start_out)
        else $error("done fell without start");
    chk_done_low_span: assert property ($fell(conversion_done_out) |-> ##[LO:HI] $rose(conversion_done_out))
        else $error("conversion length wrong");
    chk_no_busy_start: assert property (conv_start_out |-> $past(conversion_done_out))
        else $error("handoff taken while busy");
    chk_window_shut: assert property (!conversion_done_out && !$past(conversion_done_out) |-> !sampling_out)
        else $error("sampling during conversion");
    chk_addr_held: assert property (!conversion_done_out && !$past(conversion_done_out)
        |-> $stable(mux_address_out))
        else $error("address moved during conversion");
    chk_dout_quiet: assert property (!cs_bar_in && $stable(cs_bar_in) && $stable(io_clk_in)
        && $stable(frame_marker_in) |-> $stable(serial_data_out))
        else $error("output bit moved without clock edge");
    chk_reset_state: assert property ($fell(reset_in) |-> conversion_done_out && !sampling_out
        && mux_address_out == CMD_RESET)
        else $error("bad state after reset");
endmodule
bind acs_sequencer acs_sequencer_checker #(.CONV_COUNT(CONV_COUNT)) u_chk (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .io_clk_in(io_clk_in), .cs_bar_in(cs_bar_in), .frame_marker_in(frame_marker_in),
    .serial_data_out(serial_data_out), .serial_data_oe_out(serial_data_oe_out),
    .mux_address_out(mux_address_out), .sampling_out(sampling_out), .conv_start_out(conv_start_out),
    .conversion_done_out(conversion_done_out));

// file: acs_host_model.sv
// behavioural host serial port, microprocessor or dsp framing
// assumes a 160 ns link clock that stands low outside frames
`timescale 1ns/1ps
module acs_host_model (
    // from the converter
    input wire logic dout_in,
    input wire logic sampling_in,
    // to the converter
    output logic io_clk_out,
    output logic cs_bar_out,
    output logic frame_marker_out,
    output logic serial_data_out
);
    logic [11:0] rx_bits;
    logic win_seen;
    // idle: select high, clock parked low
    initial begin
        io_clk_out = 1'b0;
        cs_bar_out <= 1'b1; // nonblocking so the link flops see the clearing edge at time zero
        frame_marker_out = 1'b1;
        serial_data_out = 1'b0;
        rx_bits = 12'h000;
        win_seen = 1'b0;
    end
    // one frame of twelve clocks; data bit held across both edges so either polarity captures it
    task run_frame(input logic dsp, input logic [3:0] cmd);
        int i;
        begin
            // keep the link edges off the system clock edges
            #3;
            frame_marker_out = !dsp;
            #100 cs_bar_out = 1'b0;
            #100;
            for (i = 1; i <= 12; i++) begin
                // data moves well after the falling edge, never in its time step
                #20;
                // junk after the command shows that the input is ignored
                serial_data_out = (i <= 4) ? cmd[4-i] : !serial_data_out;
                #20;
                if (i == 7) win_seen = sampling_in;
                if (!dsp) rx_bits[12-i] = dout_in;
                else if (i == 1) rx_bits[11] = dout_in;
                #40 io_clk_out = 1'b1;
                #40;
                if (dsp && i < 12) rx_bits[11-i] = dout_in;
                #40 io_clk_out = 1'b0;
            end
            #100 cs_bar_out = 1'b1;
            // released line does not keep its last value
            serial_data_out = !serial_data_out;
            #100;
        end
    endtask
endmodule

// file: tb_top.sv
// self-checking bench: four mode/polarity frames and an extended sample
// assumes acs_pkg, the sequencer, its checker and the host model
`timescale 1ns/1ps
module tb_top;
    import acs_pkg::*;
    logic ref_clk_in = 1'b0;
    logic reset_in;
    logic pol = 1'b1;
    logic ss_bar = 1'b1;
    logic [RES_BITS-1:0] sar = RESULT_RESET;
    logic io_clk, cs_bar, fm, sdi, sdo, oe, smp, start, done;
    logic [CMD_BITS-1:0] addr;
    logic [RES_BITS-1:0] prev;
    logic [RES_BITS-1:0] res_tab [4] = '{10'h2A5, 10'h15A, 10'h3C3, 10'h0F0};
    logic [CMD_BITS-1:0] cmd_tab [4] = '{4'hA, 4'h5, 4'h3, 4'hC};
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int starts = 0;
    int k;
    always #5 ref_clk_in = ~ref_clk_in;
    // short conversion keeps the run brief
    acs_sequencer #(.CONV_COUNT(60)) DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .io_clk_in(io_clk),
        .cs_bar_in(cs_bar), .frame_marker_in(fm), .serial_data_in(sdi), .clock_polarity_select_in(pol),
        .sample_start_bar_in(ss_bar), .serial_data_out(sdo), .serial_data_oe_out(oe), .sar_result_in(sar),
        .mux_address_out(addr), .sampling_out(smp), .conv_start_out(start), .conversion_done_out(done));
    acs_host_model host (.dout_in(sdo), .sampling_in(smp), .io_clk_out(io_clk), .cs_bar_out(cs_bar),
        .frame_marker_out(fm), .serial_data_out(sdi));
    // ****
    // helpers
    // ****
    task tally_and_finish();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait on the done level, sampled away from the launching edge
    task wait_done(input logic want);
        int n;
        n = 0;
        while (done !== want && n < 300) begin
            @(negedge ref_clk_in);
            n++;
        end
        if (n >= 300) num_errors++;
    endtask
    // hang guard well above the expected run length
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // enable follows select while a frame runs; start pulses are counted mid-cycle
    always @(negedge ref_clk_in) begin
        if (cs_bar === 1'b0) begin
            check(12'(oe), 12'h001);
        end
        if (start === 1'b1) begin
            starts++;
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        reset_in <= 1'b1; // nonblocking so the mode flag sees a reset edge
        repeat (4) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        @(negedge ref_clk_in);
        check(12'(done), 12'h001);
        prev = RESULT_RESET;
        for (k = 0; k < 4; k++) begin
            @(posedge ref_clk_in);
            pol <= k[0];
            sar <= res_tab[k];
            @(posedge ref_clk_in);
            host.run_frame(k[1], cmd_tab[k]);
            check(host.rx_bits, {prev, 2'b00});
            check(12'(addr), 12'(cmd_tab[k]));
            check(12'(host.win_seen), 12'h001);
            check(12'(done), 12'h000);
            check(12'(oe), 12'h000);
            wait_done(1'b1);
            check(12'(done), 12'h001);
            prev = res_tab[k];
        end
        // extended sampling held by the start line, link idle
        @(posedge ref_clk_in);
        ss_bar <= 1'b0;
        repeat (12) @(negedge ref_clk_in);
        check(12'({smp, done}), 12'h003);
        @(posedge ref_clk_in);
        ss_bar <= 1'b1;
        wait_done(1'b0);
        check(12'(smp), 12'h000);
        wait_done(1'b1);
        // four clock handoffs and one extended start
        check(12'(starts), 12'h005);
        tally_and_finish();
    end
endmodule
